// >>> core/tafr_pkg.sv
// constants of the three-axis field readout register block
// assumes a 10 MHz system clock; all timing counts but TEMP_LP_CYCLES derive from it
package tafr_pkg;

	// ==========================================================
	// register offsets, as register pointer values
	localparam logic [7:0] REG_CTRL = 8'h27;
	localparam logic [7:0] REG_UPPER = 8'h28;
	localparam logic [7:0] REG_LOWER = 8'h29;

	// ==========================================================
	// field positions
	localparam int CTRL_STATE_LSB = 0;
	localparam int CTRL_LOOP_LSB = 2;
	localparam int CTRL_INACT_LSB = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int UP_X_LSB = 24;
	localparam int UP_Y_LSB = 16;
	localparam int UP_Z_LSB = 8;
	localparam int UP_NEW_BIT = 7;
	localparam int UP_INT_BIT = 6;
	localparam int TEMP_LSB = 0;
	localparam int LO_NVBUSY_BIT = 20;
	localparam int LO_X_LSB = 16;
	localparam int LO_Y_LSB = 12;
	localparam int LO_Z_LSB = 8;
	localparam int LO_HALL_LSB = 6;

	// ==========================================================
	// encodings
	typedef enum logic [1:0] {
		OP_ACTIVE = 2'b00,
		OP_SLEEP = 2'b01,
		OP_LOWPWR = 2'b10
	} tafr_opmode_t;

	typedef enum logic [1:0] {
		LOOP_SINGLE = 2'b00,
		LOOP_FAST = 2'b01,
		LOOP_FULL = 2'b10
	} tafr_loop_t;

	// ==========================================================
	// timing
	localparam longint CLK_HZ = 10_000_000;
	localparam longint CLK_PER_US = CLK_HZ / 1_000_000;
	localparam longint POWER_ON_DELAY_TIME_US = 1000;
	localparam longint TEMP_PERIOD_US = 8000;
	localparam logic [31:0] POD_CYC = 32'(POWER_ON_DELAY_TIME_US * CLK_PER_US);
	localparam logic [31:0] TEMP_CYC = 32'(TEMP_PERIOD_US * CLK_PER_US);
	localparam logic [3:0] TEMP_LP_CYCLES = 4'ha;
	localparam longint INACT_US [8] = '{500, 1000, 5000, 10000, 50000, 100000, 500000, 1000000};
	localparam logic [31:0] INACT_CYC [8] = '{
		32'(INACT_US[0] * CLK_PER_US), 32'(INACT_US[1] * CLK_PER_US),
		32'(INACT_US[2] * CLK_PER_US), 32'(INACT_US[3] * CLK_PER_US),
		32'(INACT_US[4] * CLK_PER_US), 32'(INACT_US[5] * CLK_PER_US),
		32'(INACT_US[6] * CLK_PER_US), 32'(INACT_US[7] * CLK_PER_US)};

endpackage

// >>> core/tafr_regs.sv
// readout and power-state registers of a three-axis field sensor, reached over i2c
// assumes: the measurement front end and interrupt comparator run on sys_clk;
// scl and sda arrive from pins and are synchronised here
//
// Function
// - primary registers always readable
// - writes need access mode, except state
// - bits 6:4 select inactive duration
// - bits 3:2 select readback loop style
// - bits 1:0: active, sleep, low power
// - upper word: xyz msbs, temperature msbs
// - new-data set on update, cleared on upper-word read
// - interrupt flag, latched until write one
// - bit 20 shows nonvolatile write busy
// - lower word: xyz lsbs, temperature lsbs
// - bits 7:6 report element combination
// - eight-byte read returns one sample
// - temperature signed, zero at 25 C
// - temperature valid, refreshed every 8 ms
// - low power: temperature every 10 cycles
// - sleep answers i2c, freezes data
// - leaving sleep waits power-on delay
// - low power alternates measure and idle
// - inactive codes 0.5 ms to 1000 ms
// - latch enable holds interrupt asserted
`timescale 1ns/1ns

module tafr_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h60,
	parameter logic [31:0] POD_CYC = tafr_pkg::POD_CYC,
	parameter logic [31:0] TEMP_CYC = tafr_pkg::TEMP_CYC,
	parameter logic [31:0] INACT_CYC [8] = tafr_pkg::INACT_CYC
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic cust_access_en,
	input wire logic int_latch_en,
	input wire logic int_nv_en,
	input wire logic nv_write_busy,
	input wire logic thresh_hit,
	input wire logic sample_valid,
	input wire logic [11:0] sample_x,
	input wire logic [11:0] sample_y,
	input wire logic [11:0] sample_z,
	input wire logic [1:0] sample_hall,
	input wire logic [11:0] sample_temp,
	output logic meas_en,
	output logic temp_conv_req,
	output logic int_out_n
);

	typedef enum logic [2:0] {
		I2_IDLE = 3'b000,
		I2_DEV = 3'b001,
		I2_PTR = 3'b010,
		I2_WR = 3'b011,
		I2_RD = 3'b100,
		I2_ACK = 3'b101,
		I2_MACK = 3'b110
	} tafr_i2c_st_t;

	typedef enum logic [2:0] {
		PW_WAKE = 3'b000,
		PW_ACTIVE = 3'b001,
		PW_SLEEP = 3'b010,
		PW_LP_ACT = 3'b011,
		PW_LP_IDLE = 3'b100
	} tafr_pwr_st_t;

	// ==========================================================
	// pin synchronisers and bus conditions
	logic scl_m_q, scl_s_q, scl_p_q;
	logic sda_m_q, sda_s_q, sda_p_q;
	logic start_c, stop_c, rise_c, fall_c;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
			scl_p_q <= 1'b1;
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			sda_p_q <= 1'b1;
		end
		else
		begin
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	assign start_c = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_c = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign rise_c = scl_s_q & ~scl_p_q;
	assign fall_c = ~scl_s_q & scl_p_q;

	// ==========================================================
	// i2c target state machine
	tafr_i2c_st_t st_q;
	logic [3:0] bitcnt_q;
	logic [7:0] shreg_q;
	logic rw_q, got_ptr_q;
	logic [7:0] ptr_q;
	logic [1:0] byte_idx_q;
	logic [23:0] wbuf_q;
	logic chain_q;
	logic byte_done, load_byte, wr_commit, snap_now;
	logic [31:0] wdata;
	logic [7:0] rd_byte;
	logic [31:0] rd_word;
	logic [7:0] next_ptr;

	assign byte_done = fall_c & (bitcnt_q == 4'h8);
	assign load_byte = fall_c & ((st_q == I2_ACK & rw_q) | st_q == I2_MACK) & ~(start_c | stop_c);
	assign wr_commit = byte_done & (st_q == I2_WR) & (byte_idx_q == 2'h3) & ~(start_c | stop_c);
	assign wdata = {wbuf_q, shreg_q};

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			st_q <= I2_IDLE;
			bitcnt_q <= 4'h0;
			shreg_q <= 8'h00;
			rw_q <= 1'b0;
			got_ptr_q <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (start_c)
		begin
			st_q <= I2_DEV;
			bitcnt_q <= 4'h0;
			got_ptr_q <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (stop_c)
		begin
			st_q <= I2_IDLE;
			sda_oe <= 1'b0;
		end
		else
		begin
			case (st_q)
				I2_DEV, I2_PTR, I2_WR:
				begin
					if (rise_c)
					begin
						shreg_q <= {shreg_q[6:0], sda_s_q};
						bitcnt_q <= bitcnt_q + 4'h1;
					end
					else if (byte_done)
					begin
						bitcnt_q <= 4'h0;
						if (st_q == I2_DEV && shreg_q[7:1] != DEV_ADDR)
							st_q <= I2_IDLE;
						else
						begin
							sda_oe <= 1'b1;
							st_q <= I2_ACK;
							if (st_q == I2_DEV)
								rw_q <= shreg_q[0];
							if (st_q == I2_PTR)
								got_ptr_q <= 1'b1;
						end
					end
				end
				I2_ACK, I2_MACK:
				begin
					if (st_q == I2_MACK && rise_c && sda_s_q)
						st_q <= I2_IDLE;
					else if (load_byte)
					begin
						shreg_q <= rd_byte;
						sda_oe <= ~rd_byte[7];
						bitcnt_q <= 4'h0;
						st_q <= I2_RD;
					end
					else if (fall_c)
					begin
						sda_oe <= 1'b0;
						st_q <= got_ptr_q ? I2_WR : I2_PTR;
					end
				end
				I2_RD:
				begin
					if (rise_c)
						bitcnt_q <= bitcnt_q + 4'h1;
					else if (byte_done)
					begin
						sda_oe <= 1'b0;
						st_q <= I2_MACK;
					end
					else if (fall_c)
					begin
						sda_oe <= ~shreg_q[6];
						shreg_q <= {shreg_q[6:0], 1'b0};
					end
				end
				default:
					st_q <= I2_IDLE;
			endcase
		end
	end

	// open drain: the data level is always low, only the enable moves
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			sda_out <= 1'b0;
		else
			sda_out <= 1'b0;
	end

	// ==========================================================
	// register pointer and byte position
	tafr_pkg::tafr_loop_t loop_q;

	always_comb
	begin
		next_ptr = ptr_q + 8'h01;
		if (ptr_q == tafr_pkg::REG_LOWER && loop_q == tafr_pkg::LOOP_FAST)
			next_ptr = tafr_pkg::REG_UPPER;
		else if (ptr_q == tafr_pkg::REG_LOWER && loop_q == tafr_pkg::LOOP_FULL)
			next_ptr = tafr_pkg::REG_CTRL;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ptr_q <= tafr_pkg::REG_UPPER;
			byte_idx_q <= 2'h0;
			wbuf_q <= 24'h00_0000;
			chain_q <= 1'b0;
		end
		else if (start_c)
			chain_q <= 1'b0;
		else if (byte_done && st_q == I2_PTR)
		begin
			ptr_q <= shreg_q;
			byte_idx_q <= 2'h0;
		end
		else if (byte_done && (st_q == I2_WR || st_q == I2_RD))
		begin
			byte_idx_q <= byte_idx_q + 2'h1;
			if (st_q == I2_WR)
				wbuf_q <= {wbuf_q[15:0], shreg_q};
			if (byte_idx_q == 2'h3)
			begin
				ptr_q <= next_ptr;
				chain_q <= (st_q == I2_RD) && (ptr_q == tafr_pkg::REG_UPPER);
			end
		end
	end

	// ==========================================================
	// control register
	tafr_pkg::tafr_opmode_t opmode_q;
	logic [2:0] inact_q;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			opmode_q <= tafr_pkg::tafr_opmode_t'(tafr_pkg::CTRL_RESET[tafr_pkg::CTRL_STATE_LSB +: 2]);
			loop_q <= tafr_pkg::tafr_loop_t'(tafr_pkg::CTRL_RESET[tafr_pkg::CTRL_LOOP_LSB +: 2]);
			inact_q <= tafr_pkg::CTRL_RESET[tafr_pkg::CTRL_INACT_LSB +: 3];
		end
		else if (wr_commit && ptr_q == tafr_pkg::REG_CTRL)
		begin
			opmode_q <= tafr_pkg::tafr_opmode_t'(wdata[tafr_pkg::CTRL_STATE_LSB +: 2]);
			if (cust_access_en)
			begin
				loop_q <= tafr_pkg::tafr_loop_t'(wdata[tafr_pkg::CTRL_LOOP_LSB +: 2]);
				inact_q <= wdata[tafr_pkg::CTRL_INACT_LSB +: 3];
			end
		end
	end

	// ==========================================================
	// power state sequencing
	tafr_pwr_st_t pw_q;
	logic [31:0] tmr_q, temp_tmr_q;
	logic [3:0] lp_cnt_q;
	logic temp_due_q;
	logic accept;

	assign accept = sample_valid & meas_en;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pw_q <= PW_WAKE;
			tmr_q <= 32'h0000_0000;
			meas_en <= 1'b0;
		end
		else
		begin
			case (pw_q)
				PW_WAKE:
				begin
					meas_en <= 1'b0;
					if (tmr_q >= POD_CYC - 32'h1)
					begin
						tmr_q <= 32'h0000_0000;
						pw_q <= (opmode_q == tafr_pkg::OP_SLEEP) ? PW_SLEEP
							: (opmode_q == tafr_pkg::OP_LOWPWR) ? PW_LP_ACT : PW_ACTIVE;
						meas_en <= opmode_q != tafr_pkg::OP_SLEEP;
					end
					else
						tmr_q <= tmr_q + 32'h1;
				end
				PW_SLEEP:
				begin
					meas_en <= 1'b0;
					tmr_q <= 32'h0000_0000;
					if (opmode_q != tafr_pkg::OP_SLEEP)
						pw_q <= PW_WAKE;
				end
				PW_LP_IDLE:
				begin
					if (opmode_q != tafr_pkg::OP_LOWPWR)
					begin
						pw_q <= (opmode_q == tafr_pkg::OP_SLEEP) ? PW_SLEEP : PW_ACTIVE;
						meas_en <= opmode_q != tafr_pkg::OP_SLEEP;
					end
					else if (tmr_q >= INACT_CYC[inact_q] - 32'h1)
					begin
						pw_q <= PW_LP_ACT;
						meas_en <= 1'b1;
					end
					else
						tmr_q <= tmr_q + 32'h1;
				end
				default:
				begin
					// active and low-power measuring phase
					if (opmode_q == tafr_pkg::OP_SLEEP)
					begin
						pw_q <= PW_SLEEP;
						meas_en <= 1'b0;
					end
					else if (opmode_q == tafr_pkg::OP_LOWPWR && (pw_q == PW_ACTIVE || accept))
					begin
						pw_q <= accept ? PW_LP_IDLE : PW_LP_ACT;
						meas_en <= ~accept;
						tmr_q <= 32'h0000_0000;
					end
					else if (opmode_q != tafr_pkg::OP_LOWPWR)
					begin
						pw_q <= PW_ACTIVE;
						meas_en <= 1'b1;
					end
				end
			endcase
		end
	end

	// temperature conversion request: timed in active state, counted in low power
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			temp_tmr_q <= 32'h0000_0000;
			lp_cnt_q <= 4'h0;
			temp_due_q <= 1'b0;
		end
		else if (pw_q == PW_ACTIVE)
		begin
			if (temp_tmr_q >= TEMP_CYC - 32'h1)
			begin
				temp_tmr_q <= 32'h0000_0000;
				temp_due_q <= 1'b1;
			end
			else
			begin
				temp_tmr_q <= temp_tmr_q + 32'h1;
				if (accept)
					temp_due_q <= 1'b0;
			end
		end
		else if (pw_q == PW_LP_ACT && accept)
		begin
			if (lp_cnt_q >= tafr_pkg::TEMP_LP_CYCLES - 4'h1)
			begin
				lp_cnt_q <= 4'h0;
				temp_due_q <= 1'b1;
			end
			else
			begin
				lp_cnt_q <= lp_cnt_q + 4'h1;
				temp_due_q <= 1'b0;
			end
		end
		else if (pw_q == PW_WAKE)
			temp_tmr_q <= 32'h0000_0000;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			temp_conv_req <= 1'b0;
		else
			temp_conv_req <= temp_due_q;
	end

	// ==========================================================
	// measurement data and flags
	logic [11:0] x_q, y_q, z_q, temp_q;
	logic [1:0] hall_q;
	logic new_q, int_q, nv_busy_q;
	logic w1c_int;

	assign w1c_int = wr_commit & (ptr_q == tafr_pkg::REG_UPPER) & cust_access_en & wdata[tafr_pkg::UP_INT_BIT];

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			x_q <= 12'h000;
			y_q <= 12'h000;
			z_q <= 12'h000;
			hall_q <= 2'h0;
			temp_q <= 12'h000;
		end
		else if (accept)
		begin
			x_q <= sample_x;
			y_q <= sample_y;
			z_q <= sample_z;
			hall_q <= sample_hall;
			if (temp_conv_req)
				temp_q <= sample_temp;
		end
	end

	// a flag that is set and cleared in one cycle stays set
	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			new_q <= 1'b0;
			int_q <= 1'b0;
			nv_busy_q <= 1'b0;
			int_out_n <= 1'b1;
		end
		else
		begin
			new_q <= accept | (new_q & ~(snap_now & ptr_q == tafr_pkg::REG_UPPER));
			if (int_latch_en)
				int_q <= thresh_hit | (int_q & ~w1c_int);
			else
				int_q <= thresh_hit;
			nv_busy_q <= int_nv_en & nv_write_busy;
			int_out_n <= ~int_q;
		end
	end

	// ==========================================================
	// read path with coherent snapshot
	logic [31:0] up_live, lo_live, up_snap_q, lo_snap_q;

	always_comb
	begin
		up_live = 32'h0000_0000;
		up_live[tafr_pkg::UP_X_LSB +: 8] = x_q[11:4];
		up_live[tafr_pkg::UP_Y_LSB +: 8] = y_q[11:4];
		up_live[tafr_pkg::UP_Z_LSB +: 8] = z_q[11:4];
		up_live[tafr_pkg::UP_NEW_BIT] = new_q;
		up_live[tafr_pkg::UP_INT_BIT] = int_q;
		up_live[tafr_pkg::TEMP_LSB +: 6] = temp_q[11:6];
		lo_live = 32'h0000_0000;
		lo_live[tafr_pkg::LO_NVBUSY_BIT] = nv_busy_q;
		lo_live[tafr_pkg::LO_X_LSB +: 4] = x_q[3:0];
		lo_live[tafr_pkg::LO_Y_LSB +: 4] = y_q[3:0];
		lo_live[tafr_pkg::LO_Z_LSB +: 4] = z_q[3:0];
		lo_live[tafr_pkg::LO_HALL_LSB +: 2] = hall_q;
		lo_live[tafr_pkg::TEMP_LSB +: 6] = temp_q[5:0];
	end

	// both words are caught when the first byte of the pair is loaded
	assign snap_now = load_byte & (byte_idx_q == 2'h0)
		& (ptr_q == tafr_pkg::REG_UPPER | (ptr_q == tafr_pkg::REG_LOWER & ~chain_q));

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			up_snap_q <= 32'h0000_0000;
			lo_snap_q <= 32'h0000_0000;
		end
		else if (snap_now)
		begin
			up_snap_q <= up_live;
			lo_snap_q <= lo_live;
		end
	end

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (ptr_q == tafr_pkg::REG_CTRL)
			rd_word = {25'h0, inact_q, loop_q, opmode_q};
		else if (ptr_q == tafr_pkg::REG_UPPER)
			rd_word = snap_now ? up_live : up_snap_q;
		else if (ptr_q == tafr_pkg::REG_LOWER)
			rd_word = snap_now ? lo_live : lo_snap_q;
		rd_byte = rd_word[8'(31 - 8 * int'(byte_idx_q)) -: 8];
	end

endmodule // tafr_regs

// >>> verif/tafr_regs_chk.sv
// port checks for tafr_regs, bound to every instance
// assumes sda resolved outside with a pull-up; reset async, active low
`timescale 1ns/1ns

module tafr_regs_chk #(
	parameter logic [31:0] POD_CYC = 32'h2710
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic cust_access_en,
	input wire logic int_latch_en,
	input wire logic int_nv_en,
	input wire logic nv_write_busy,
	input wire logic thresh_hit,
	input wire logic sample_valid,
	input wire logic [11:0] sample_x,
	input wire logic [11:0] sample_y,
	input wire logic [11:0] sample_z,
	input wire logic [1:0] sample_hall,
	input wire logic [11:0] sample_temp,
	input wire logic meas_en,
	input wire logic temp_conv_req,
	input wire logic int_out_n
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!arst_n);

	// ==========
	// cycles since release, saturating
	logic [31:0] since_q;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
			since_q <= 32'h0;
		else if (since_q != 32'hffff_ffff)
			since_q <= since_q + 32'h1;
	end

	// ==========
	// assertions
	a_pod_quiet: assert property (since_q + 32'h1 < POD_CYC |-> !meas_en)
		else $error("measuring inside power-on delay");
	a_int_follows: assert property (!int_latch_en [*3] ##0 $past(arst_n, 3) |-> int_out_n == !$past(thresh_hit, 2))
		else $error("unlatched interrupt not following comparison");
	a_int_sets: assert property (int_latch_en && thresh_hit |-> ##2 !int_out_n)
		else $error("latched interrupt not raised");
	a_int_clear: assert property (int_latch_en [*3] ##0 $rose(int_out_n) |->
		$past(sda_oe) || $past(sda_oe, 2) || $past(sda_oe, 3))
		else $error("latched interrupt cleared without a write");
	// the request pin copies the due flag one cycle late, so the accepting sample sits two cycles back
	a_temp_clear: assert property ($fell(temp_conv_req) |-> $past(sample_valid && meas_en, 2))
		else $error("temperature request dropped without a sample");
	a_meas_drop: assert property ($fell(meas_en) |->
		$past(sample_valid) || $past(sda_oe) || $past(sda_oe, 2) || $past(sda_oe, 3))
		else $error("measuring stopped without cause");
	a_sda_steady: assert property (scl_in [*4] |-> $stable(sda_oe))
		else $error("sda changed while scl high");
	a_sda_low: assert property (sda_oe |-> sda_out == 1'b0)
		else $error("sda driven high");

	c_latch: cover property (int_latch_en && thresh_hit);
	c_meas_drop: cover property ($fell(meas_en));
	c_ack: cover property ($rose(sda_oe));

endmodule // tafr_regs_chk

bind tafr_regs tafr_regs_chk #(.POD_CYC(POD_CYC)) tafr_regs_chk_inst (.*);

// >>> verif/tafr_i2c_host.sv
// i2c host model: drives scl and its own pull on sda in quarter-bit steps
// assumes the bench resolves sda from all pulls with a pull-up
`timescale 1ns/1ns

module tafr_i2c_host (
	input wire logic sys_clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda_pull
);
	// 5 clocks a quarter bit leaves room for the 2-flop sync and ack delay
	localparam int Q = 5;

	initial
	begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end

	// ==========
	// bus steps; scl stays high between frames
	task automatic step();
		repeat (Q) @(negedge sys_clk);
	endtask

	task automatic bit_io(input logic b, output logic s);
		step();
		sda_pull = !b;
		step();
		scl = 1'b1;
		step();
		s = sda_line;
		step();
		scl = 1'b0;
	endtask

	task automatic start();
		sda_pull = 1'b0;
		step();
		scl = 1'b1;
		step();
		sda_pull = 1'b1;
		step();
		scl = 1'b0;
	endtask

	task automatic stop();
		sda_pull = 1'b1;
		step();
		scl = 1'b1;
		step();
		sda_pull = 1'b0;
		step();
	endtask

	task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(tx[i], rx[i]);
		bit_io(mack, ack);
	endtask

endmodule // tafr_i2c_host

// >>> verif/test_tafr_regs.sv
// self-checking bench: i2c host model reaches the registers,
// the bench plays the measuring front end and comparator
`timescale 1ns/1ns

module test_tafr_regs;
	localparam logic [31:0] POD = 32'h64;
	localparam logic [31:0] INACT [8] = '{32'h0a, 32'h14, 32'h1e, 32'h28, 32'h32, 32'h3c, 32'h46, 32'h50};
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic scl_in, sda_pull, sda_out, sda_oe, meas_en, temp_conv_req, int_out_n, req_at;
	logic cust_access_en = 1'b0, int_latch_en = 1'b0, int_nv_en = 1'b0, nv_write_busy = 1'b0;
	logic thresh_hit = 1'b0, sample_valid = 1'b0;
	logic [11:0] sample_x = 12'h0, sample_y = 12'h0, sample_z = 12'h0, sample_temp = 12'h0;
	logic [1:0] sample_hall = 2'h0;
	logic [31:0] rng = 32'h2ed8;
	logic [31:0] pu, pl, eu, el;
	logic [63:0] d;
	int failures = 0, checked = 0, low_run = 0, last_low = 0;
	wire sda_in = !(sda_pull || (sda_oe && !sda_out));

	always #50 sys_clk = !sys_clk;

	always @(posedge sys_clk)
	begin
		if (meas_en === 1'b1)
		begin
			if (low_run != 0)
				last_low = low_run;
			low_run = 0;
		end
		else
			low_run++;
	end

	tafr_i2c_host host_inst (.sys_clk(sys_clk), .sda_line(sda_in), .scl(scl_in), .sda_pull(sda_pull));

	tafr_regs #(.POD_CYC(POD), .TEMP_CYC(32'h32), .INACT_CYC(INACT)) tafr_regs_inst (.sys_clk(sys_clk),
		.arst_n(arst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
		.cust_access_en(cust_access_en), .int_latch_en(int_latch_en), .int_nv_en(int_nv_en),
		.nv_write_busy(nv_write_busy), .thresh_hit(thresh_hit), .sample_valid(sample_valid),
		.sample_x(sample_x), .sample_y(sample_y), .sample_z(sample_z), .sample_hall(sample_hall),
		.sample_temp(sample_temp), .meas_en(meas_en), .temp_conv_req(temp_conv_req), .int_out_n(int_out_n));

	// ==========
	// helpers
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// new random sample; model words land in pu/pl
	task automatic pulse(input bit tw);
		logic [31:0] r;
		int k;
		r = xs();
		sample_x = r[11:0];
		sample_y = r[23:12];
		sample_hall = (r[31:30] == 2'h3) ? 2'h2 : r[31:30];
		r = xs();
		sample_z = r[11:0];
		sample_temp = r[23:12];
		int_nv_en = r[24];
		nv_write_busy = r[25];
		k = 0;
		while (((tw && temp_conv_req !== 1'b1) || meas_en !== 1'b1) && k < 200)
		begin
			@(negedge sys_clk);
			k++;
		end
		if (tw)
			check("temp_req", temp_conv_req, 32'h1);
		req_at = temp_conv_req;
		sample_valid = 1'b1;
		@(negedge sys_clk);
		sample_valid = 1'b0;
		pu = {sample_x[11:4], sample_y[11:4], sample_z[11:4], 2'b10, sample_temp[11:6]};
		pl = {11'h0, int_nv_en & nv_write_busy, sample_x[3:0], sample_y[3:0], sample_z[3:0], sample_hall,
			sample_temp[5:0]};
	endtask

	task automatic wr(input logic [7:0] ptr, input logic [31:0] v);
		logic [7:0] b;
		logic a;
		host_inst.start();
		host_inst.xfer(8'hc0, 1'b1, b, a);
		check("wr_ack", a, 32'h0);
		host_inst.xfer(ptr, 1'b1, b, a);
		for (int i = 3; i >= 0; i--)
			host_inst.xfer(v[8*i +: 8], 1'b1, b, a);
		host_inst.stop();
	endtask

	task automatic rd(input logic [7:0] ptr, input int n, input bit mid);
		logic [7:0] b;
		logic a;
		host_inst.start();
		host_inst.xfer(8'hc0, 1'b1, b, a);
		host_inst.xfer(ptr, 1'b1, b, a);
		host_inst.start();
		host_inst.xfer(8'hc1, 1'b1, b, a);
		check("rd_ack", a, 32'h0);
		for (int i = 0; i < n; i++)
		begin
			if (mid && i == 1)
				pulse(1'b1);
			host_inst.xfer(8'hff, i == n - 1, b, a);
			d = {d[55:0], b};
		end
		host_inst.stop();
	endtask

	// ==========
	// scenarios
	initial
	begin
		logic [31:0] r;
		int k;
		int last;
		int gap;
		last = -1;
		gap = 0;
		repeat (12) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (120) @(negedge sys_clk);
		rd(8'h27, 4, 1'b0);
		check("ctrl_rst", d[31:0], 32'h0);
		wr(8'h27, 32'hffff_ffff);
		rd(8'h27, 4, 1'b0);
		check("ctrl_lock", d[31:0], 32'h3);
		cust_access_en = 1'b1;
		r = xs() & 32'hffff_fffc;
		wr(8'h27, r);
		rd(8'h27, 4, 1'b0);
		check("ctrl_rw", d[31:0], r & 32'h7c);
		rd(8'h2a, 4, 1'b0);
		check("unmapped", d[31:0], 32'h0);
		for (int j = 0; j < 2; j++)
		begin
			pulse(1'b1);
			eu = pu;
			el = pl;
			rd(8'h28, 8, 1'b1);
			check("upper", d[63:32], eu);
			check("lower", d[31:0], el);
			eu = pu;
			el = pl;
			rd(8'h28, 8, 1'b0);
			check("upper_new", d[63:32], eu);
			check("lower_new", d[31:0], el);
			check("x_join", {20'h0, d[63:56], d[19:16]}, {20'h0, sample_x});
			eu[7] = 1'b0;
			rd(8'h28, 4, 1'b0);
			check("upper_old", d[31:0], eu);
		end
		// loop styles: after the lower word the pointer wraps instead of running on
		wr(8'h27, 32'h4);
		rd(8'h29, 8, 1'b0);
		check("loop_fast_lo", d[63:32], el);
		check("loop_fast_up", d[31:0], eu);
		wr(8'h27, 32'h8);
		rd(8'h29, 8, 1'b0);
		check("loop_full_lo", d[63:32], el);
		check("loop_full_ctrl", d[31:0], 32'h8);
		repeat (40)
		begin
			@(negedge sys_clk);
			r = xs();
			thresh_hit = r[0];
		end
		thresh_hit = 1'b0;
		int_latch_en = 1'b1;
		@(negedge sys_clk);
		thresh_hit = 1'b1;
		@(negedge sys_clk);
		thresh_hit = 1'b0;
		repeat (3) @(negedge sys_clk);
		check("int_pin", int_out_n, 32'h0);
		rd(8'h28, 4, 1'b0);
		check("int_bit", d[6], 32'h1);
		cust_access_en = 1'b0;
		wr(8'h28, 32'h40);
		check("int_locked", int_out_n, 32'h0);
		cust_access_en = 1'b1;
		wr(8'h28, 32'h40);
		check("int_clr", int_out_n, 32'h1);
		int_latch_en = 1'b0;
		wr(8'h27, 32'h1);
		check("sleep_meas", meas_en, 32'h0);
		pulse(1'b0);
		rd(8'h28, 8, 1'b0);
		check("sleep_data", d[63:39], {eu[31:8], 1'b0});
		wr(8'h27, 32'h0);
		check("wake_wait", meas_en, 32'h0);
		k = 0;
		while (meas_en !== 1'b1 && k < 200)
		begin
			@(negedge sys_clk);
			k++;
		end
		check("wake_done", meas_en, 32'h1);
		for (int j = 0; j < 30; j++)
		begin
			if (j < 8)
				wr(8'h27, {25'h0, 3'(j), 4'h2});
			pulse(1'b0);
			@(negedge sys_clk);
			check("lp_drop", meas_en, 32'h0);
			k = 0;
			while (meas_en !== 1'b1 && k < 200)
			begin
				@(negedge sys_clk);
				k++;
			end
			@(negedge sys_clk);
			if (j < 8)
				check("lp_idle", last_low >= INACT[j] && last_low <= INACT[j] + 32'h2, 32'h1);
			if (req_at === 1'b1 && j >= 8)
			begin
				if (last >= 0)
					gap = j - last;
				last = j;
			end
		end
		check("lp_temp", gap, 32'ha);
		report_and_stop();
	end

	// generous bound over the expected run length
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		failures++;
		report_and_stop();
	end

endmodule // test_tafr_regs
